// [include/epsi_pkg.sv]
// Constants, modes and the CRC helper shared by both link ends.
// Assumes a 200 MHz core clock on both ends.
package epsi_pkg;
   localparam int CLK_NS = 5;
   localparam int ST_BITS = 18;
   localparam int MT_BITS = 32;
   localparam int HD_BIT_CYC = 80;
   localparam int HD_FRAME_BITS = 10;
   localparam logic [2:0] SYNC_CODE = 3'h2;
   localparam logic [3:0] CMD_POS_REQ = 4'h3;
   localparam logic [7:0] CTRL_POS_REQ = {^{CMD_POS_REQ, SYNC_CODE}, CMD_POS_REQ, SYNC_CODE};
   localparam int SET_SPACE_NS = 62500;
   localparam int SET_SPACE_CYC = (SET_SPACE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [5:0] CRC_POLY = 6'h03;
   localparam int BISS_FAST_NS = 200;
   localparam int BISS_FAST_HALF_CYC = BISS_FAST_NS / CLK_NS / 2;
   localparam int BISS_TIMEOUT_NS = 5000;
   localparam int BISS_TIMEOUT_CYC = BISS_TIMEOUT_NS / CLK_NS;
   localparam int MONOFLOP_NS = 20000;
   localparam int MONOFLOP_CYC = MONOFLOP_NS / CLK_NS;
   localparam int SSI_PAUSE_NS = 21000;
   localparam int SSI_PAUSE_CYC = (SSI_PAUSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int LINK_HALF_CYC = 40;
   localparam int ACK_MAX = 8;

   typedef enum logic [2:0] {
      EPSI_HD = 3'h1,
      EPSI_BISS = 3'h2,
      EPSI_SSI = 3'h4
   } epsi_mode_type;

   // Remainder over the low n bits of d, MSB first
   function automatic logic [5:0] epsi_crc6(input logic [63:0] d, input int n);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 63; i >= 0; i--) begin
         if (i < n) begin
            c = {c[4:0], 1'b0} ^ ((c[5] ^ d[i]) ? CRC_POLY : 6'h00);
         end
      end
      return c;
   endfunction : epsi_crc6
endpackage : epsi_pkg

// [include/epsi_link_if.sv]
// Link between encoder end and host end: shared half-duplex line,
// host clock and encoder data. Assumes pull-up idle on the shared line.
`timescale 1ns/1ps
`default_nettype none
interface epsi_link_if;
   logic hd_host_out;
   logic hd_host_oe;
   logic hd_dev_out;
   logic hd_dev_oe;
   logic hd_line;
   logic ma;
   logic slo;

   // Undriven line floats high through the terminator bias
   assign hd_line = hd_dev_oe ? hd_dev_out : (hd_host_oe ? hd_host_out : 1'b1);

   modport device (input hd_line, input ma, output hd_dev_out, output hd_dev_oe, output slo);
   modport host (input hd_line, input slo, output hd_host_out, output hd_host_oe, output ma);
endinterface : epsi_link_if
`default_nettype wire

// [design/epsi_device.sv]
// Encoder end of the position link: half-duplex command link,
// clocked frame with CRC, and plain shift frame, one mode at a time.
// Assumes the link pins are asynchronous; user inputs are on core_clk.
// Contract
// - One host, act only on its requests.
// - Check start, data field, stop first.
// - Set starts only on valid sync code.
// - Set ends when no start follows.
// - Idle line level is high.
// - Host spaces position requests by cycle time.
// - CRC x^6+x+1, sent inverted.
// - Error bit low on any error.
// - Warning bit low on any warning.
// - Position width is single plus multi turn.
`timescale 1ns/1ps
`default_nettype none
module epsi_device #(
   parameter int ST_W = epsi_pkg::ST_BITS,
   parameter int MT_W = epsi_pkg::MT_BITS,
   parameter int ERR_N = 4,
   parameter int WARN_N = 4,
   parameter int BIT_CYC = epsi_pkg::HD_BIT_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire epsi_pkg::epsi_mode_type mode,
   input wire logic [ST_W-1:0] single_turn_count,
   input wire logic [MT_W-1:0] multi_turn_count,
   input wire logic [ERR_N-1:0] error_status,
   input wire logic [WARN_N-1:0] warning_status,
   epsi_link_if.device link,
   output logic cmd_strobe,
   output logic [3:0] cmd_code,
   output logic pos_latch
);
   import epsi_pkg::*;

   localparam int PW = ST_W + MT_W;
   localparam int NB = (PW + 7) / 8 + 2;
   localparam int PB = (NB - 2) * 8;
   localparam int TXW = NB * HD_FRAME_BITS;
   localparam int FW = PW + 10;
   // Timers stop one cycle after reaching zero, hence the minus one
   localparam logic [15:0] BIT_T = 16'(BIT_CYC - 1);
   localparam logic [15:0] HALF_T = 16'(BIT_CYC / 2 - 1);
   localparam logic [15:0] GAP_T = 16'(2 * BIT_CYC);
   localparam logic [15:0] TIMEOUT_T = 16'(BISS_TIMEOUT_CYC);
   localparam logic [15:0] MONO_T = 16'(MONOFLOP_CYC);
   localparam logic [5:0] FAST_T = 6'(BISS_FAST_HALF_CYC);

   if (PW > 54 || ST_W < 1 || MT_W < 1 || BIT_CYC < 8 || BIT_CYC > 16000) begin : g_bad
      $error("epsi_device: unsupported width or bit rate");
   end

   typedef enum logic [3:0] {
      HD_HUNT = 4'h1,
      HD_RECV = 4'h2,
      HD_GAP = 4'h4,
      HD_SEND = 4'h8
   } epsi_hd_state_type;

   typedef enum logic [4:0] {
      CS_IDLE = 5'h01,
      CS_LEAD = 5'h02,
      CS_BUSY = 5'h04,
      CS_SHIFT = 5'h08,
      CS_TAIL = 5'h10
   } epsi_cs_state_type;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] line_sync;
   logic [1:0] ma_sync;
   logic ma_prev;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         line_sync <= 2'h3;
         ma_sync <= 2'h3;
         ma_prev <= 1'b1;
      end else begin
         line_sync <= {line_sync[0], link.hd_line};
         ma_sync <= {ma_sync[0], link.ma};
         ma_prev <= ma_sync[1];
      end
   end

   wire logic line_in = line_sync[1];
   wire logic ma_in = ma_sync[1];
   wire logic ma_rise = ma_in && !ma_prev;
   wire logic ma_fall = !ma_in && ma_prev;

   ////////////////////////////////////////////////////////////////////
   // Shared position word and status bits
   wire logic [PW-1:0] position = {multi_turn_count, single_turn_count};
   wire logic combined_error_flag_low = ~|error_status;
   wire logic combined_warning_flag_low = ~|warning_status;

   ////////////////////////////////////////////////////////////////////
   // Half-duplex command link
   epsi_hd_state_type hd_state;
   logic [15:0] hd_timer;
   logic [3:0] hd_idx;
   logic [7:0] rx_byte;
   logic [7:0] set_ctrl;
   logic first_frame;
   logic [TXW-1:0] tx_sr;
   logic [TXW-1:0] tx_frames;
   logic [7:0] tx_left;

   wire logic hd_on = (mode == EPSI_HD);
   wire logic hd_tick = (hd_timer == 16'h0);
   wire logic [7:0] rx_next = {line_in, rx_byte[7:1]};
   wire logic [PB-1:0] pos_pad = PB'(position);
   wire logic [NB*8-1:0] reply = {6'h00, combined_warning_flag_low, combined_error_flag_low, pos_pad, set_ctrl};
   wire logic sync_bad = first_frame && (rx_next[7:5] != SYNC_CODE);
   wire logic frame_bad = !line_in || (^rx_byte);

   for (genvar i = 0; i < NB; i++) begin : g_frame
      assign tx_frames[i*HD_FRAME_BITS +: HD_FRAME_BITS] = {1'b1, reply[i*8 +: 8], 1'b0};
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hd_state <= HD_HUNT;
         hd_timer <= 16'h0;
         hd_idx <= 4'h0;
         rx_byte <= 8'hff;
         set_ctrl <= 8'h00;
         first_frame <= 1'b1;
         tx_sr <= '1;
         tx_left <= 8'h00;
         cmd_strobe <= 1'b0;
         cmd_code <= 4'h0;
      end else begin
         cmd_strobe <= 1'b0;
         hd_timer <= hd_tick ? 16'h0 : hd_timer - 16'h1;
         case (hd_state)
            HD_HUNT: begin
               // Any low after idle may open a set
               if (hd_on && !line_in) begin
                  hd_state <= HD_RECV;
                  hd_timer <= HALF_T;
                  hd_idx <= 4'h0;
                  first_frame <= 1'b1;
               end
            end
            HD_RECV: begin
               if (hd_tick) begin
                  hd_timer <= BIT_T;
                  hd_idx <= hd_idx + 4'h1;
                  if (hd_idx >= 4'h1 && hd_idx <= 4'h8) begin
                     rx_byte <= rx_next;
                  end
                  if (hd_idx == 4'h0 && line_in) begin
                     hd_state <= HD_HUNT;
                  end else if (hd_idx == 4'h3 && sync_bad) begin
                     hd_state <= HD_HUNT;
                  end else if (hd_idx == 4'h9) begin
                     if (frame_bad) begin
                        hd_state <= HD_HUNT;
                     end else begin
                        if (first_frame) begin
                           set_ctrl <= rx_byte;
                        end
                        first_frame <= 1'b0;
                        hd_state <= HD_GAP;
                        hd_timer <= GAP_T;
                     end
                  end
               end
            end
            HD_GAP: begin
               if (!line_in) begin
                  hd_state <= HD_RECV;
                  hd_timer <= HALF_T;
                  hd_idx <= 4'h0;
               end else if (hd_tick) begin
                  // No further start: the set is over, act on it
                  cmd_strobe <= 1'b1;
                  cmd_code <= set_ctrl[6:3];
                  if (set_ctrl[6:3] == CMD_POS_REQ) begin
                     hd_state <= HD_SEND;
                     tx_sr <= tx_frames;
                     tx_left <= 8'(TXW);
                     hd_timer <= BIT_T;
                  end else begin
                     hd_state <= HD_HUNT;
                  end
               end
            end
            HD_SEND: begin
               if (hd_tick) begin
                  tx_sr <= {1'b1, tx_sr[TXW-1:1]};
                  tx_left <= tx_left - 8'h01;
                  hd_timer <= BIT_T;
                  if (tx_left == 8'h01) begin
                     hd_state <= HD_HUNT;
                  end
               end
            end
            default: hd_state <= HD_HUNT;
         endcase
      end
   end

   assign link.hd_dev_out = tx_sr[0];
   assign link.hd_dev_oe = (hd_state == HD_SEND);

   ////////////////////////////////////////////////////////////////////
   // Clocked links
   epsi_cs_state_type cs_state;
   logic [FW-1:0] cs_sr;
   logic [6:0] cs_left;
   logic [15:0] quiet;
   logic [5:0] half_cnt;
   logic busy_left;
   logic slo_q;

   wire logic is_biss = (mode == EPSI_BISS);
   wire logic clk_mode = is_biss || (mode == EPSI_SSI);
   wire logic [PW+1:0] crc_in = {position, combined_error_flag_low, combined_warning_flag_low};
   wire logic [5:0] crc_rem = epsi_crc6(64'(crc_in), PW + 2);
   wire logic [FW-1:0] biss_frame = {1'b1, 1'b0, crc_in, ~crc_rem};
   wire logic [FW-1:0] ssi_frame = {position, 10'h000};
   // Tail ends on the short timeout; elsewhere the monoflop ends SSI frames and abandoned ones
   wire logic [15:0] quiet_lim = (cs_state == CS_TAIL) ? TIMEOUT_T : MONO_T;
   wire logic quiet_out = (cs_state != CS_IDLE) && (quiet >= quiet_lim);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cs_state <= CS_IDLE;
         cs_sr <= '0;
         cs_left <= 7'h00;
         quiet <= 16'h0;
         half_cnt <= 6'h00;
         busy_left <= 1'b0;
         slo_q <= 1'b1;
         pos_latch <= 1'b0;
      end else begin
         pos_latch <= 1'b0;
         if (ma_rise || ma_fall) begin
            quiet <= 16'h0;
         end else if (quiet != 16'hffff) begin
            quiet <= quiet + 16'h1;
         end
         if (quiet_out) begin
            cs_state <= CS_IDLE;
            slo_q <= 1'b1;
         end else begin
            case (cs_state)
               CS_IDLE: begin
                  slo_q <= 1'b1;
                  if (clk_mode && ma_fall) begin
                     cs_state <= CS_LEAD;
                     cs_sr <= is_biss ? biss_frame : ssi_frame;
                     cs_left <= is_biss ? 7'(FW) : 7'(PW);
                     half_cnt <= 6'h00;
                     pos_latch <= 1'b1;
                  end
               end
               CS_LEAD: begin
                  if (half_cnt != 6'h3f) begin
                     half_cnt <= half_cnt + 6'h01;
                  end
                  if (ma_rise && is_biss) begin
                     // One busy period, two at the fast clock
                     slo_q <= 1'b0;
                     busy_left <= (half_cnt <= FAST_T);
                     cs_state <= CS_BUSY;
                  end else if (ma_rise) begin
                     slo_q <= cs_sr[FW-1];
                     cs_sr <= {cs_sr[FW-2:0], 1'b0};
                     cs_left <= cs_left - 7'h01;
                     cs_state <= CS_SHIFT;
                  end
               end
               CS_BUSY: begin
                  if (ma_rise && busy_left) begin
                     busy_left <= 1'b0;
                  end else if (ma_rise) begin
                     slo_q <= cs_sr[FW-1];
                     cs_sr <= {cs_sr[FW-2:0], 1'b0};
                     cs_left <= cs_left - 7'h01;
                     cs_state <= CS_SHIFT;
                  end
               end
               CS_SHIFT: begin
                  if (ma_rise && cs_left == 7'h00) begin
                     slo_q <= 1'b0;
                     cs_state <= CS_TAIL;
                  end else if (ma_rise) begin
                     slo_q <= cs_sr[FW-1];
                     cs_sr <= {cs_sr[FW-2:0], 1'b0};
                     cs_left <= cs_left - 7'h01;
                  end
               end
               CS_TAIL: slo_q <= 1'b0;
               default: cs_state <= CS_IDLE;
            endcase
         end
      end
   end

   assign link.slo = slo_q;
endmodule : epsi_device
`default_nettype wire

// [design/epsi_host.sv]
// Host end of the position link: issues position requests on the
// chosen option and returns the word read back.
// Assumes the link pins are asynchronous; user side is on core_clk.
`timescale 1ns/1ps
`default_nettype none
module epsi_host #(
   parameter int ST_W = epsi_pkg::ST_BITS,
   parameter int MT_W = epsi_pkg::MT_BITS,
   parameter int BIT_CYC = epsi_pkg::HD_BIT_CYC,
   parameter int SET_SPACE = epsi_pkg::SET_SPACE_CYC,
   parameter int SSI_PAUSE = epsi_pkg::SSI_PAUSE_CYC,
   parameter int HALF_CYC = epsi_pkg::LINK_HALF_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire epsi_pkg::epsi_mode_type mode,
   input wire logic req,
   output logic req_ready,
   epsi_link_if.host link,
   output logic pos_valid,
   output logic [ST_W+MT_W-1:0] position,
   output logic err_low,
   output logic warn_low,
   output logic check_ok,
   output logic link_fault
);
   import epsi_pkg::*;

   localparam int PW = ST_W + MT_W;
   localparam int NB = (PW + 7) / 8 + 2;
   localparam int BW = PW + 9;
   localparam logic [15:0] BIT_T = 16'(BIT_CYC - 1);
   localparam logic [15:0] HALF_T = 16'(BIT_CYC / 2 - 1);
   localparam logic [15:0] WAIT_T = 16'(BIT_CYC * 16);
   localparam logic [15:0] CLK_T = 16'(HALF_CYC - 1);
   localparam logic [15:0] DRAIN_T = 16'(BISS_TIMEOUT_CYC * 2);

   if (PW > 54 || BIT_CYC < 8 || BIT_CYC > 4000 || HALF_CYC < 10 || HALF_CYC > 1000
       || SET_SPACE > 65535 || SSI_PAUSE > 65535) begin : g_bad
      $error("epsi_host: unsupported width or timing");
   end

   typedef enum logic [5:0] {
      H_IDLE = 6'h01,
      H_TX = 6'h02,
      H_WAIT = 6'h04,
      H_RX = 6'h08,
      H_CLK = 6'h10,
      H_DRAIN = 6'h20
   } epsi_host_state_type;

   ////////////////////////////////////////////////////////////////////
   logic [1:0] line_sync;
   logic [1:0] slo_sync;
   epsi_host_state_type h_state;
   logic [15:0] timer;
   logic [15:0] space;
   logic [3:0] idx;
   logic [7:0] byte_cnt;
   logic [9:0] tx_sr;
   logic [NB*8-1:0] rx_sr;
   logic [BW-1:0] bsr;
   logic [6:0] samp_cnt;
   logic ma_q;
   logic saw_low;
   logic started;
   logic last;

   wire logic line_in = line_sync[1];
   wire logic slo_in = slo_sync[1];
   wire logic tick = (timer == 16'h0);
   wire logic is_biss = (mode == EPSI_BISS);
   wire logic [NB*8-1:0] rx_next = {line_in, rx_sr[NB*8-1:1]};
   wire logic [BW-1:0] bsr_next = {bsr[BW-2:0], slo_in};
   wire logic [5:0] crc_rem = epsi_crc6(64'(bsr[BW-2:6]), PW + 2);

   assign req_ready = (h_state == H_IDLE) && (space == 16'h0);
   assign link.hd_host_out = tx_sr[0];
   assign link.hd_host_oe = (h_state == H_TX);
   assign link.ma = ma_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         line_sync <= 2'h3;
         slo_sync <= 2'h3;
      end else begin
         line_sync <= {line_sync[0], link.hd_line};
         slo_sync <= {slo_sync[0], link.slo};
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (rst) begin
         h_state <= H_IDLE;
         timer <= 16'h0;
         space <= 16'h0;
         idx <= 4'h0;
         byte_cnt <= 8'h00;
         tx_sr <= 10'h3ff;
         rx_sr <= '0;
         bsr <= '0;
         samp_cnt <= 7'h00;
         ma_q <= 1'b1;
         saw_low <= 1'b0;
         started <= 1'b0;
         last <= 1'b0;
         pos_valid <= 1'b0;
         position <= '0;
         err_low <= 1'b1;
         warn_low <= 1'b1;
         check_ok <= 1'b0;
         link_fault <= 1'b0;
      end else begin
         pos_valid <= 1'b0;
         link_fault <= 1'b0;
         timer <= tick ? 16'h0 : timer - 16'h1;
         if (space != 16'h0) begin
            space <= space - 16'h1;
         end
         case (h_state)
            H_IDLE: begin
               if (req && req_ready && mode == EPSI_HD) begin
                  tx_sr <= {1'b1, CTRL_POS_REQ, 1'b0};
                  space <= 16'(SET_SPACE);
                  idx <= 4'h0;
                  byte_cnt <= 8'h00;
                  timer <= BIT_T;
                  h_state <= H_TX;
               end else if (req && req_ready && mode != EPSI_HD) begin
                  ma_q <= 1'b0;
                  timer <= CLK_T;
                  samp_cnt <= 7'h00;
                  saw_low <= 1'b0;
                  started <= 1'b0;
                  last <= 1'b0;
                  h_state <= H_CLK;
               end
            end
            H_TX: begin
               if (tick) begin
                  tx_sr <= {1'b1, tx_sr[9:1]};
                  idx <= idx + 4'h1;
                  timer <= BIT_T;
                  if (idx == 4'h9) begin
                     h_state <= H_WAIT;
                     timer <= WAIT_T;
                  end
               end
            end
            H_WAIT: begin
               if (!line_in) begin
                  idx <= 4'h0;
                  timer <= HALF_T;
                  h_state <= H_RX;
               end else if (tick) begin
                  link_fault <= 1'b1;
                  h_state <= H_IDLE;
               end
            end
            H_RX: begin
               if (tick) begin
                  idx <= idx + 4'h1;
                  timer <= BIT_T;
                  if (idx >= 4'h1 && idx <= 4'h8) begin
                     rx_sr <= rx_next;
                  end
                  if ((idx == 4'h0 && line_in) || (idx == 4'h9 && !line_in)) begin
                     link_fault <= 1'b1;
                     h_state <= H_IDLE;
                  end else if (idx == 4'h9 && byte_cnt == 8'(NB - 1)) begin
                     position <= rx_sr[8 +: PW];
                     err_low <= rx_sr[NB*8-8];
                     warn_low <= rx_sr[NB*8-7];
                     check_ok <= (rx_sr[7:0] == CTRL_POS_REQ);
                     pos_valid <= 1'b1;
                     h_state <= H_IDLE;
                  end else if (idx == 4'h9) begin
                     byte_cnt <= byte_cnt + 8'h01;
                     timer <= WAIT_T;
                     h_state <= H_WAIT;
                  end
               end
            end
            H_CLK: begin
               if (tick && !ma_q) begin
                  ma_q <= 1'b1;
                  timer <= CLK_T;
               end else if (tick) begin
                  // Sample just before the falling edge
                  timer <= CLK_T;
                  ma_q <= 1'b0;
                  if (!is_biss) begin
                     bsr <= bsr_next;
                     samp_cnt <= samp_cnt + 7'h01;
                     if (samp_cnt == 7'(PW - 1)) begin
                        ma_q <= 1'b1;
                        position <= bsr_next[PW-1:0];
                        check_ok <= 1'b1;
                        pos_valid <= 1'b1;
                        space <= 16'(SSI_PAUSE);
                        h_state <= H_IDLE;
                     end
                  end else if (last) begin
                     ma_q <= 1'b1;
                     timer <= DRAIN_T;
                     h_state <= H_DRAIN;
                  end else if (started) begin
                     bsr <= bsr_next;
                     samp_cnt <= samp_cnt + 7'h01;
                     last <= (samp_cnt == 7'(BW - 1));
                  end else if (!slo_in) begin
                     saw_low <= 1'b1;
                  end else if (saw_low) begin
                     started <= 1'b1;
                     samp_cnt <= 7'h00;
                  end else if (samp_cnt == 7'(ACK_MAX)) begin
                     link_fault <= 1'b1;
                     ma_q <= 1'b1;
                     timer <= DRAIN_T;
                     h_state <= H_DRAIN;
                  end else begin
                     samp_cnt <= samp_cnt + 7'h01;
                  end
               end
            end
            H_DRAIN: begin
               // Line back high ends the device timeout
               if (slo_in && last) begin
                  position <= bsr[BW-2:8];
                  err_low <= bsr[7];
                  warn_low <= bsr[6];
                  check_ok <= (bsr[5:0] == ~crc_rem);
                  pos_valid <= 1'b1;
                  h_state <= H_IDLE;
               end else if (slo_in) begin
                  h_state <= H_IDLE;
               end else if (tick) begin
                  link_fault <= 1'b1;
                  h_state <= H_IDLE;
               end
            end
            default: h_state <= H_IDLE;
         endcase
      end
   end
endmodule : epsi_host
`default_nettype wire

// [testbench/epsi_link_properties.sv]
// Checker for the link wires between both ends.
// Assumes one core_clk for both ends.
`timescale 1ns/1ps
`default_nettype none
module epsi_link_properties (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic hd_host_out,
   input wire logic hd_host_oe,
   input wire logic hd_dev_out,
   input wire logic hd_dev_oe,
   input wire logic hd_line,
   input wire logic ma,
   input wire logic slo
);
   logic [12:0] quiet;
   logic ma_q;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Saturates so the quiet checks stay armed
   always_ff @(posedge core_clk) begin
      ma_q <= ma;
      if (rst || ma != ma_q) quiet <= 13'h0000;
      else if (quiet != 13'h1fff) quiet <= quiet + 13'h0001;
   end
   ////////////////////////////////////////
   AST_ONE_TALKER: assert property (!(hd_host_oe && hd_dev_oe))
      else $error("both ends drive the line");
   AST_HOST_IDLE: assert property ($fell(hd_host_oe) |-> $past(hd_host_out))
      else $error("host released line low");
   AST_SET_END: assert property ($fell(hd_host_oe) |=> !hd_dev_oe [*8])
      else $error("reply before set end");
   AST_DEV_START: assert property ($rose(hd_dev_oe) |-> ##[0:1] !hd_dev_out)
      else $error("reply without start bit");
   AST_DEV_HOLD: assert property ($rose(hd_dev_oe) |=> hd_dev_oe [*8])
      else $error("reply dropped early");
   AST_MA_HALF: assert property ($changed(ma) |=> $stable(ma) [*8])
      else $error("host clock half too short");
   AST_MONOFLOP: assert property (quiet > 13'hfaa |-> slo)
      else $error("data not idle after quiet time");
   AST_SLO_EDGE: assert property ($changed(slo) |-> quiet < 13'h8 || quiet > 13'h3d0)
      else $error("data moved off clock edge");
endmodule : epsi_link_properties
`default_nettype wire

// [testbench/tb.sv]
// Bench joining both link ends, reading position in each mode.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import epsi_pkg::*;
   logic core_clk, rst, req, req_ready, pos_valid, err_low, warn_low, check_ok;
   logic link_fault, cmd_strobe, pos_latch;
   logic [3:0] cmd_code, err_s, warn_s;
   logic [17:0] st;
   logic [31:0] mt, lf;
   logic [49:0] position;
   epsi_mode_type mode;
   int n_fail, compares, n_latch;
   epsi_link_if link ();
   epsi_device epsi_device_inst (.core_clk, .rst, .mode, .single_turn_count(st),
      .multi_turn_count(mt), .error_status(err_s), .warning_status(warn_s),
      .link(link), .cmd_strobe, .cmd_code, .pos_latch);
   epsi_host epsi_host_inst (.core_clk, .rst, .mode, .req, .req_ready, .link(link),
      .pos_valid, .position, .err_low, .warn_low, .check_ok, .link_fault);
   epsi_link_properties props_inst (.core_clk, .rst, .hd_host_out(link.hd_host_out),
      .hd_host_oe(link.hd_host_oe), .hd_dev_out(link.hd_dev_out),
      .hd_dev_oe(link.hd_dev_oe), .hd_line(link.hd_line), .ma(link.ma), .slo(link.slo));
   ////////////////////////////////////////
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   function automatic logic exp_flag(input logic [3:0] s);
      return ~|s;
   endfunction : exp_flag
   task automatic chk(input string nm, input logic [49:0] got, input logic [49:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("fails %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   // Bounded wait, sampled at negedge where outputs are settled
   task automatic wt(input bit v);
      int k;
      k = 0;
      while ((v ? pos_valid : req_ready) !== 1'b1 && k < 20000) begin
         @(negedge core_clk);
         k++;
      end
      if (k >= 20000) begin
         n_fail++;
         report_and_stop();
      end
   endtask : wt
   ////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   always @(negedge core_clk) begin
      if (cmd_strobe === 1'b1) chk("cmd", cmd_code, CMD_POS_REQ);
      if (pos_latch === 1'b1) n_latch++;
      if (link_fault !== 1'b0) chk("fault", link_fault, 50'h0);
   end
   initial begin
      repeat (96000) @(posedge core_clk);
      n_fail++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      req = 1'b0;
      mode = EPSI_HD;
      lf = 32'hcdc3;
      st = '0;
      mt = '0;
      err_s = 4'h0;
      warn_s = 4'h0;
      n_fail = 0;
      compares = 0;
      n_latch = 0;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      for (int m = 0; m < 3; m++) begin
         @(posedge core_clk);
         mode <= epsi_mode_type'(3'h1 << m);
         // Corners first: position all zero, all one, then random
         for (int i = 0; i < 3; i++) begin
            lf = nxt(nxt(lf));
            @(posedge core_clk);
            st <= (i == 0) ? '0 : (i == 1) ? '1 : lf[17:0];
            mt <= (i == 0) ? '0 : (i == 1) ? '1 : nxt(lf);
            err_s <= (i == 0) ? 4'hf : (i == 1) ? 4'h0 : lf[21:18];
            warn_s <= (i == 0) ? 4'h0 : (i == 1) ? 4'h8 : lf[25:22];
            wt(1'b0);
            @(posedge core_clk);
            req <= 1'b1;
            @(posedge core_clk);
            req <= 1'b0;
            wt(1'b1);
            chk("pos", position, {mt, st});
            chk("crc", check_ok, 50'h1);
            if (mode != EPSI_SSI) begin
               chk("err", err_low, exp_flag(err_s));
               chk("warn", warn_low, exp_flag(warn_s));
            end
         end
         chk("latch", 50'(n_latch), 50'(3 * m));
         // Let the device fall idle before the mode moves
         repeat (4500) @(posedge core_clk);
      end
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
